/* File: hdl/dpc_pkg.sv */
package dpc_pkg;
	// Channel count and data widths
	localparam int NUM_CH = 2;
	localparam int POS_W = 32;
	localparam int CNT_W = 16;
	localparam int PAR_AW = 16;
	localparam int PAR_DW = 32;

	// Parameter addresses, two 16-bit words each, 32-bit values at their base word
	localparam logic [15:0] ADDR_STATUS = 16'h0A02;
	localparam logic [15:0] ADDR_EDGE1 = 16'h0A04;
	localparam logic [15:0] ADDR_EDGE2 = 16'h0A06;
	localparam logic [15:0] ADDR_ARM1 = 16'h0A08;
	localparam logic [15:0] ADDR_ARM2 = 16'h0A0A;
	localparam logic [15:0] ADDR_POS1 = 16'h0A0C;
	localparam logic [15:0] ADDR_POS2 = 16'h0A0E;
	localparam logic [15:0] ADDR_TALLY1 = 16'h0A10;
	localparam logic [15:0] ADDR_TALLY2 = 16'h0A12;
	localparam logic [15:0] ADDR_EDGE [NUM_CH] = '{ADDR_EDGE1, ADDR_EDGE2};
	localparam logic [15:0] ADDR_ARM [NUM_CH] = '{ADDR_ARM1, ADDR_ARM2};

	// Field values and positions
	localparam logic EDGE_FALL = 1'b0;
	localparam logic EDGE_RISE = 1'b1;
	localparam logic EDGE_RST = EDGE_FALL;
	localparam logic [1:0] ARM_STOP = 2'h0;
	localparam logic [1:0] ARM_ONCE = 2'h1;
	localparam logic [1:0] ARM_CONT = 2'h2;
	localparam int WARN_POS_BIT = 13;

	typedef enum logic [1:0] {
		MODE_IDLE = 2'b00,
		MODE_ONCE = 2'b01,
		MODE_CONT = 2'b10
	} dpc_mode_type;
endpackage

/* File: hdl/dpc_channel.sv */
`timescale 1ns/1ps
module dpc_channel
	import dpc_pkg::*;
#(
	parameter int CW = CNT_W,
	parameter int PW = POS_W
) (
	// Clock and synchronised reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Capture pin, raw
	input wire logic trig_i,
	// Configuration and arming
	input wire logic edge_rise_i,
	input wire logic arm_wr_i,
	input wire logic [1:0] arm_code_i,
	// Drive position and reference redefinition
	input wire logic [PW-1:0] pos_i,
	input wire logic adj_i,
	input wire logic [PW-1:0] delta_i,
	// Channel state
	output dpc_mode_type mode_o,
	output logic captured_o,
	output logic [CW-1:0] tally_o,
	output logic [PW-1:0] pos_o
);
	if (CW < 1 || PW < 1) begin : g_bad_width
		$error("dpc_channel: widths must be positive");
	end

	typedef struct packed {
		logic sync1;
		logic sync2;
		logic prev;
		dpc_mode_type mode;
		logic captured;
		logic [CW-1:0] tally;
		logic [PW-1:0] pos;
	} dpc_ch_type;

	dpc_ch_type st_ff;
	dpc_ch_type nxt_st;
	logic hit;
	logic arming;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.sync1 = trig_i;
		nxt_st.sync2 = st_ff.sync1;
		nxt_st.prev = st_ff.sync2;
		// One event per synchronised transition of the chosen polarity
		hit = (st_ff.mode != MODE_IDLE) && (st_ff.sync2 != st_ff.prev) && (st_ff.sync2 == edge_rise_i);
		arming = arm_wr_i && (arm_code_i != ARM_STOP);
		if (hit) begin
			nxt_st.pos = pos_i;
			nxt_st.tally = st_ff.tally + CW'(1);
		end else if (adj_i) begin
			// Keeps the stored value on the new position reference
			nxt_st.pos = st_ff.pos + delta_i;
		end
		if (hit && st_ff.mode == MODE_ONCE) begin
			nxt_st.mode = MODE_IDLE;
		end
		// Continuous mode simply stays in place on a hit
		if (arm_wr_i) begin
			nxt_st.mode = dpc_mode_type'(arm_code_i);
		end
		if (arming) begin
			nxt_st.tally = '0;
		end
		// An event in the arming cycle still shows as captured
		nxt_st.captured = hit | (st_ff.captured & ~arming);
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign mode_o = st_ff.mode;
	assign captured_o = st_ff.captured;
	assign tally_o = st_ff.tally;
	assign pos_o = st_ff.pos;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	a_once_disarms: assert property (st_ff.mode == MODE_ONCE && hit && !arm_wr_i |=> st_ff.mode == MODE_IDLE)
		else $error("single capture did not disarm");
	a_idle_ignores: assert property (st_ff.mode == MODE_IDLE && !arm_wr_i && !adj_i
		|=> $stable(st_ff.pos) && $stable(st_ff.tally) && $stable(st_ff.captured))
		else $error("capture while disarmed");
	a_cont_stays: assert property (st_ff.mode == MODE_CONT && hit && !arm_wr_i |=> st_ff.mode == MODE_CONT)
		else $error("continuous capture dropped");
	a_arm_now: assert property (arm_wr_i |=> st_ff.mode == dpc_mode_type'($past(arm_code_i)))
		else $error("arm write not applied at once");
	a_tally_clear: assert property (arming |=> st_ff.tally == '0)
		else $error("tally not cleared on arming");
	a_tally_step: assert property (hit && !arming |=> st_ff.tally == CW'($past(st_ff.tally) + CW'(1)))
		else $error("tally did not count event");
	a_pos_latch: assert property (hit |=> st_ff.pos == $past(pos_i) && st_ff.captured)
		else $error("position not latched");
	a_pos_adjust: assert property (!hit && adj_i |=> st_ff.pos == PW'($past(st_ff.pos) + $past(delta_i)))
		else $error("position not rebased");
	a_edge_pick: assert property (st_ff.mode != MODE_IDLE && !arm_wr_i && !adj_i
		&& st_ff.sync2 != edge_rise_i && st_ff.prev == edge_rise_i |=> $stable(st_ff.pos) && $stable(st_ff.tally))
		else $error("capture on wrong edge");
endmodule

/* File: hdl/dpc_capture_unit.sv */
`timescale 1ns/1ps
module dpc_capture_unit
	import dpc_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// Capture pins
	input wire logic first_trigger_input_i,
	input wire logic second_trigger_input_i,
	// Drive position, same clock
	input wire logic [POS_W-1:0] pos_i,
	input wire logic pos_redef_i,
	input wire logic [POS_W-1:0] pos_redef_delta_i,
	// Parameter access
	input wire logic par_req_i,
	input wire logic par_we_i,
	input wire logic [PAR_AW-1:0] par_addr_i,
	input wire logic [PAR_DW-1:0] par_wdata_i,
	output logic par_ack_o,
	output logic par_err_o,
	output logic [PAR_DW-1:0] par_rdata_o,
	// Warning word
	output logic [15:0] latched_warning_word_o
);
	typedef struct packed {
		logic [NUM_CH-1:0] edge_sel;
		logic ack;
		logic err;
		logic [PAR_DW-1:0] rdata;
		logic [15:0] warn;
	} dpc_top_type;

	logic [1:0] rst_sync_ff;
	logic rst_n;
	dpc_top_type st_ff;
	dpc_top_type nxt_st;

	logic [NUM_CH-1:0] trig;
	logic [NUM_CH-1:0] arm_wr;
	dpc_mode_type mode [NUM_CH];
	logic [NUM_CH-1:0] captured;
	logic [CNT_W-1:0] tally [NUM_CH];
	logic [POS_W-1:0] cpos [NUM_CH];
	logic wr;
	logic rd;
	logic arm_ok;

	// Decode and status layout are written for exactly two channels
	if (NUM_CH != 2 || WARN_POS_BIT > 15 || POS_W > PAR_DW || CNT_W > PAR_DW) begin : g_bad_pkg
		$error("dpc_capture_unit: package constants out of range");
	end

	// Release is synchronous so no flop leaves reset on a different edge
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_sync_ff <= 2'h0;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_ff[1];

	assign trig = {second_trigger_input_i, first_trigger_input_i};
	assign wr = par_req_i & par_we_i;
	assign rd = par_req_i & ~par_we_i;
	assign arm_ok = par_wdata_i <= PAR_DW'(ARM_CONT);

	// Both channels are the same logic with private state
	for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
		// Arm write goes straight to the channel so it acts on this edge
		assign arm_wr[i] = wr && arm_ok && (par_addr_i == ADDR_ARM[i]);
		dpc_channel #(
			.CW(CNT_W),
			.PW(POS_W)
		) u_ch (
			.clk_i(clk_i),
			.rst_n_i(rst_n),
			.trig_i(trig[i]),
			.edge_rise_i(st_ff.edge_sel[i]),
			.arm_wr_i(arm_wr[i]),
			.arm_code_i(par_wdata_i[1:0]),
			.pos_i(pos_i),
			.adj_i(pos_redef_i),
			.delta_i(pos_redef_delta_i),
			.mode_o(mode[i]),
			.captured_o(captured[i]),
			.tally_o(tally[i]),
			.pos_o(cpos[i])
		);
	end

	always_comb begin
		nxt_st = st_ff;
		nxt_st.ack = par_req_i;
		nxt_st.err = 1'b0;
		nxt_st.rdata = '0;
		// Running capture means the captured position is not yet valid
		nxt_st.warn = '0;
		nxt_st.warn[WARN_POS_BIT] = (mode[0] != MODE_IDLE) || (mode[1] != MODE_IDLE);
		if (par_req_i) begin
			unique case (par_addr_i)
				ADDR_STATUS: begin
					nxt_st.err = wr;
					nxt_st.rdata = PAR_DW'(captured);
				end
				ADDR_EDGE1, ADDR_EDGE2: begin
					if (wr && par_wdata_i > PAR_DW'(EDGE_RISE)) begin
						nxt_st.err = 1'b1;
					end else if (wr) begin
						// New polarity is used from the next edge on
						nxt_st.edge_sel[par_addr_i == ADDR_EDGE2] = par_wdata_i[0];
					end
					nxt_st.rdata = PAR_DW'(st_ff.edge_sel[par_addr_i == ADDR_EDGE2]);
				end
				ADDR_ARM1, ADDR_ARM2: begin
					nxt_st.err = wr & ~arm_ok;
					// Readback shows live mode, so a finished single capture reads 0
					nxt_st.rdata = PAR_DW'(mode[par_addr_i == ADDR_ARM2]);
				end
				ADDR_POS1, ADDR_POS2: begin
					nxt_st.err = wr;
					nxt_st.rdata = cpos[par_addr_i == ADDR_POS2];
				end
				ADDR_TALLY1, ADDR_TALLY2: begin
					// Counter is read-only from the host side
					nxt_st.err = wr;
					nxt_st.rdata = PAR_DW'(tally[par_addr_i == ADDR_TALLY2]);
				end
				default: begin
					nxt_st.err = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '0;
			st_ff.edge_sel <= {NUM_CH{EDGE_RST}};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign par_ack_o = st_ff.ack;
	assign par_err_o = st_ff.err;
	assign par_rdata_o = st_ff.rdata;
	assign latched_warning_word_o = st_ff.warn;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n);

	a_warn_running: assert property ((mode[0] != MODE_IDLE || mode[1] != MODE_IDLE)
		|=> latched_warning_word_o[WARN_POS_BIT])
		else $error("position-invalid warning missing");
	a_warn_clears: assert property (mode[0] == MODE_IDLE && mode[1] == MODE_IDLE
		|=> !latched_warning_word_o[WARN_POS_BIT])
		else $error("position-invalid warning stuck");
	a_warn_spare: assert property ((latched_warning_word_o & ~(16'h0001 << WARN_POS_BIT)) == 16'h0000)
		else $error("unexpected warning bit set");
	a_status_map: assert property (rd && par_addr_i == ADDR_STATUS
		|=> par_ack_o && par_rdata_o == PAR_DW'($past(captured)))
		else $error("status word wrong");
	a_status_clear: assert property (arm_wr[0] && par_wdata_i[1:0] != ARM_STOP && mode[0] == MODE_IDLE
		|=> !captured[0])
		else $error("status bit kept over arming");
	a_edge_write: assert property (wr && par_addr_i == ADDR_EDGE2 && par_wdata_i <= PAR_DW'(1)
		|=> st_ff.edge_sel[1] == $past(par_wdata_i[0]) && st_ff.edge_sel[0] == $past(st_ff.edge_sel[0]))
		else $error("edge select write wrong");
	a_edge_read: assert property (rd && par_addr_i == ADDR_EDGE1
		|=> par_rdata_o == PAR_DW'($past(st_ff.edge_sel[0])))
		else $error("edge select readback wrong");
	a_edge_reject: assert property (wr && par_addr_i == ADDR_EDGE2 && par_wdata_i > PAR_DW'(EDGE_RISE)
		|=> par_err_o && $stable(st_ff.edge_sel))
		else $error("illegal edge select accepted");
	a_arm_apply: assert property (wr && par_addr_i == ADDR_ARM1 && arm_ok
		|=> mode[0] == dpc_mode_type'($past(par_wdata_i[1:0])))
		else $error("arm write not applied");
	a_arm2_apply: assert property (wr && par_addr_i == ADDR_ARM2 && arm_ok
		|=> mode[1] == dpc_mode_type'($past(par_wdata_i[1:0])))
		else $error("second channel arm write not applied");
	a_arm_read: assert property (rd && par_addr_i == ADDR_ARM2
		|=> par_rdata_o == PAR_DW'($past(mode[1])))
		else $error("arm readback wrong");
	a_arm_reject: assert property (wr && par_addr_i == ADDR_ARM1 && !arm_ok
		|=> par_err_o && (mode[0] == $past(mode[0]) || $past(mode[0]) == MODE_ONCE))
		else $error("illegal arm code accepted");
	a_ch_isolated: assert property (arm_wr[1] && !arm_wr[0] && mode[0] != MODE_ONCE
		|=> mode[0] == $past(mode[0]))
		else $error("channel two write disturbed channel one");
	a_tally_clear: assert property (arm_wr[1] && par_wdata_i[1:0] != ARM_STOP |=> tally[1] == '0)
		else $error("tally not cleared on arming");
	a_tally_read: assert property (rd && par_addr_i == ADDR_TALLY1
		|=> par_rdata_o == PAR_DW'($past(tally[0])))
		else $error("tally readback wrong");
	a_tally_ro: assert property (wr && par_addr_i == ADDR_TALLY1
		|=> par_err_o && (tally[0] == $past(tally[0])
		|| $past(mode[0]) != MODE_IDLE && tally[0] == $past(tally[0]) + CNT_W'(1)))
		else $error("tally accepted a write");
	a_pos_read: assert property (rd && par_addr_i == ADDR_POS2
		|=> par_rdata_o == $past(cpos[1]))
		else $error("position readback wrong");
	a_pos_unpaired: assert property (par_req_i && par_addr_i == ADDR_POS1 + 16'h0001
		|=> par_err_o && par_rdata_o == '0)
		else $error("upper position word answered");
	a_pos_rebase: assert property (pos_redef_i && mode[0] == MODE_IDLE
		|=> cpos[0] == $past(cpos[0]) + $past(pos_redef_delta_i))
		else $error("captured position not rebased");
	a_ack_next: assert property (par_req_i |=> par_ack_o)
		else $error("access not acknowledged");
	a_ack_single: assert property (!par_req_i |=> !par_ack_o && !par_err_o && par_rdata_o == '0)
		else $error("answer outside its access cycle");
endmodule

/* File: test/dpc_pin_src.sv */
`timescale 1ns/1ps
module dpc_pin_src (
	// Clock
	input wire logic clk_i,
	// Control from the bench
	input wire logic pulse_i,
	input wire logic pol_i,
	// Capture pin
	output logic pin_o
);
	logic [2:0] cnt_ff = 3'h0;

	// Four cycles wide so the two sync flops can never miss the pulse
	always_ff @(posedge clk_i) begin
		cnt_ff <= pulse_i ? 3'h4 : cnt_ff - {2'h0, cnt_ff != 3'h0};
	end

	// Idle level follows pol_i, so a pol change alone makes a single edge
	assign pin_o = pol_i ^ (cnt_ff != 3'h0);
endmodule

/* File: test/dual_position_capture_unit_tb_top.sv */
`timescale 1ns/1ps
module dual_position_capture_unit_tb_top;
	import dpc_pkg::*;
	typedef struct packed {logic we; logic [15:0] a; logic [31:0] d; logic e; logic [31:0] r;} dpc_row_type;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic req = 1'b0;
	logic we = 1'b0;
	logic redef = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [31:0] wd = 32'h0;
	logic [31:0] pos = 32'h0;
	logic [31:0] delta = 32'h0;
	logic [1:0] pls = 2'h0;
	logic [1:0] pol = 2'h2;
	logic [1:0] pin;
	logic ack;
	logic err;
	logic [31:0] rd;
	logic [15:0] warn;
	int n_errors = 0;
	int comparisons = 0;
	int cyc = 0;
	// Reset values, refused writes and an unmapped word
	dpc_row_type rows [12] = '{
		'{0, ADDR_STATUS, 0, 0, 0}, '{0, ADDR_EDGE1, 0, 0, 0}, '{0, ADDR_EDGE2, 0, 0, 0},
		'{0, ADDR_ARM2, 0, 0, 0}, '{0, ADDR_TALLY1, 0, 0, 0}, '{0, ADDR_POS2, 0, 0, 0},
		'{1, ADDR_STATUS, 1, 1, 0}, '{1, ADDR_TALLY1, 1, 1, 0}, '{1, ADDR_POS1, 1, 1, 0},
		'{1, ADDR_ARM1, 3, 1, 0}, '{1, ADDR_EDGE2, 2, 1, 0}, '{0, 16'h0A0D, 0, 1, 0}};

	dpc_capture_unit dut (.clk_i(clk_i), .nrst_i(nrst_i), .first_trigger_input_i(pin[0]),
		.second_trigger_input_i(pin[1]), .pos_i(pos), .pos_redef_i(redef), .pos_redef_delta_i(delta),
		.par_req_i(req), .par_we_i(we), .par_addr_i(addr), .par_wdata_i(wd), .par_ack_o(ack),
		.par_err_o(err), .par_rdata_o(rd), .latched_warning_word_o(warn));
	dpc_pin_src src0 (.clk_i(clk_i), .pulse_i(pls[0]), .pol_i(pol[0]), .pin_o(pin[0]));
	dpc_pin_src src1 (.clk_i(clk_i), .pulse_i(pls[1]), .pol_i(pol[1]), .pin_o(pin[1]));

	initial begin
		forever #20 clk_i = ~clk_i;
	end

	task automatic results;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// One access; answer is looked at in its single ack cycle
	task automatic par(input logic w, input logic [15:0] a, input logic [31:0] d, input logic e,
		input logic [31:0] r);
		@(posedge clk_i);
		req <= 1'b1;
		we <= w;
		addr <= a;
		wd <= d;
		@(posedge clk_i);
		req <= 1'b0;
		#1;
		chk("ack", {31'h0, ack}, 32'h1);
		chk("err", {31'h0, err}, {31'h0, e});
		if (!w)
			chk("rdata", rd, r);
	endtask

	// Pulse or level change on one pin, position held across the capture
	task automatic drv(input int c, input logic pl, input logic pv, input logic [31:0] ps);
		@(posedge clk_i);
		pls[c] <= pl;
		pol[c] <= pv;
		pos <= ps;
		@(posedge clk_i);
		pls[c] <= 1'b0;
		wt(8);
	endtask

	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_errors++;
			results();
		end
	end

	initial begin
		wt(10);
		nrst_i <= 1'b1;
		wt(4);
		foreach (rows[i])
			par(rows[i].we, rows[i].a, rows[i].d, rows[i].e, rows[i].r);
		par(1, ADDR_EDGE1, 1, 0, 0);
		par(1, ADDR_ARM1, ARM_ONCE, 0, 0);
		par(0, ADDR_ARM1, 0, 0, ARM_ONCE);
		drv(0, 1, 0, 32'hFFFF_FFF0);
		drv(0, 1, 0, 32'h0000_0055);
		par(0, ADDR_POS1, 0, 0, 32'hFFFF_FFF0);
		par(0, ADDR_TALLY1, 0, 0, 1);
		par(0, ADDR_ARM1, 0, 0, ARM_STOP);
		par(1, ADDR_ARM2, ARM_CONT, 0, 0);
		par(0, ADDR_ARM2, 0, 0, ARM_CONT);
		chk("warn", {16'h0, warn}, 32'h2000);
		drv(1, 1, 1, 32'h0000_0100);
		drv(1, 1, 1, 32'h0000_0200);
		par(0, ADDR_POS2, 0, 0, 32'h0000_0200);
		par(0, ADDR_TALLY2, 0, 0, 2);
		par(0, ADDR_STATUS, 0, 0, 3);
		par(1, ADDR_ARM2, ARM_STOP, 0, 0);
		drv(1, 1, 1, 32'h0000_0300);
		par(0, ADDR_TALLY2, 0, 0, 2);
		chk("warn", {16'h0, warn}, 32'h0);
		@(posedge clk_i);
		redef <= 1'b1;
		delta <= 32'h0000_0020;
		@(posedge clk_i);
		redef <= 1'b0;
		par(0, ADDR_POS1, 0, 0, 32'h0000_0010);
		par(1, ADDR_ARM1, ARM_CONT, 0, 0);
		par(0, ADDR_TALLY1, 0, 0, 0);
		par(0, ADDR_STATUS, 0, 0, 2);
		par(1, ADDR_EDGE1, 0, 0, 0);
		drv(0, 0, 1, 32'h0000_0400);
		par(0, ADDR_TALLY1, 0, 0, 0);
		drv(0, 0, 0, 32'h0000_0500);
		par(0, ADDR_TALLY1, 0, 0, 1);
		par(0, ADDR_POS1, 0, 0, 32'h0000_0500);
		par(1, ADDR_EDGE2, 1, 0, 0);
		// Second reset in mid-run must bring every register back
		@(posedge clk_i);
		nrst_i <= 1'b0;
		wt(3);
		nrst_i <= 1'b1;
		wt(4);
		par(0, ADDR_EDGE2, 0, 0, 0);
		par(0, ADDR_TALLY2, 0, 0, 0);
		par(0, ADDR_STATUS, 0, 0, 0);
		chk("warn", {16'h0, warn}, 32'h0);
		results();
	end
endmodule
